/* rtl/synth_cfg_device.sv */
// serial slave, register bank and frequency decode of the clock synthesizer
// What this block does
// - decode select code into cpu pll settings
// - reference pll fixed; link rate from top bit
// - all registers take defaults at reset
// - controller uses link only for configuration
// - byte write, byte read, block write, block read
// - block bytes ascending, msb first, stop anytime
// - answer only slave address 69h (d2h write)
// - command bit 7 picks single or block
// - command bits 6-0 give single index
// - block write count byte unless two-wire mode
// - block read returns count then data bytes
// - controller nacks last read byte, then stops
// - byte write acks three bytes, updates register
// - byte read returns one indexed byte
// - register 0 enables differential reference outputs
// - register 1 enables misc, reference, cpu outputs
// - register 2 enables 33 mhz outputs
// - register 3 top bits enable link outputs
// - register 3 low bits pick drive strength
// - straps caught once at first power-good low; test mode recaptures while power-good is low
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
module synth_cfg_device (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link
  serial_cfg_if.dev link,
  // straps and mode pins
  input wire logic strap_freq_bit3_i,
  input wire logic strap_freq_bit2_i,
  input wire logic strap_freq_bit1_i,
  input wire logic strap_freq_bit0_i,
  input wire logic power_good_strobe_n_i,
  input wire logic test_mode_i,
  input wire logic two_wire_mode_i,
  // output enables and drive strengths
  output logic [4:0] diff_ref_out_en_o,
  output logic shared_diff_out0_enable_o,
  output logic disk_video_clk_enable_o,
  output logic sel_24_48_out_enable_o,
  output logic out_48mhz_enable_o,
  output logic [2:0] crystal_ref_out_en_o,
  output logic [1:0] cpu_out_en_o,
  output logic [5:0] bus33_out_en_o,
  output logic [1:0] chipset_link_out_en_o,
  output logic bus33_drive_single_o,
  output logic ref_drive_single_o,
  output logic usb48_drive_single_o,
  // frequency decode
  output logic [3:0] freq_code_o,
  output logic [6:0] cpu_m_o,
  output logic [8:0] cpu_n_o,
  output logic [7:0] cpu_gear_o,
  output logic [6:0] ref_m_o,
  output logic [8:0] ref_n_o,
  output logic [7:0] ref_gear_o,
  output logic link_fast_o
);
  // ---------------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] scl_s, sda_s;
  logic [6:0] pin_s1, pin_s2;
  always_ff @(posedge clk_i) begin
    scl_s <= {scl_s[1:0], link.scl};
    sda_s <= {sda_s[1:0], link.sda};
    pin_s1 <= {power_good_strobe_n_i, test_mode_i, two_wire_mode_i, strap_freq_bit3_i,
               strap_freq_bit2_i, strap_freq_bit1_i, strap_freq_bit0_i};
    pin_s2 <= pin_s1;
  end
  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start_ev = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_ev = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  // ---------------------------------------------------------------------------
  // strap capture and frequency decode
  // ---------------------------------------------------------------------------
  logic strap_done_q;
  logic [3:0] freq_code_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_done_q <= 1'b0;
      freq_code_q <= 4'h0;
    end else if (!pin_s2[6] && (!strap_done_q || pin_s2[5])) begin
      strap_done_q <= 1'b1;
      freq_code_q <= pin_s2[3:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_m_o <= clk_synth_pkg::CPU_M_STD;
      cpu_n_o <= clk_synth_pkg::CPU_N_STD;
      cpu_gear_o <= 8'h00;
      link_fast_o <= 1'b0;
    end else begin
      cpu_gear_o <= clk_synth_pkg::CPU_GEAR_TBL[freq_code_q[2:0]];
      link_fast_o <= freq_code_q[clk_synth_pkg::LINK_SEL_BIT];
      cpu_m_o <= clk_synth_pkg::CPU_M_STD;
      case (freq_code_q[2:0])
        3'h3, 3'h4: begin
          cpu_m_o <= clk_synth_pkg::CPU_M_ALT;
          cpu_n_o <= clk_synth_pkg::CPU_N_ALT;
        end
        3'h7: cpu_n_o <= clk_synth_pkg::CPU_N_MIX;
        default: cpu_n_o <= clk_synth_pkg::CPU_N_STD;
      endcase
    end
  end
  // reference pll never follows the select code
  always_ff @(posedge clk_i) begin
    freq_code_o <= freq_code_q;
    ref_m_o <= clk_synth_pkg::REF_M;
    ref_n_o <= clk_synth_pkg::REF_N;
    ref_gear_o <= clk_synth_pkg::REF_GEAR;
  end
  // ---------------------------------------------------------------------------
  // serial slave state machine
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {ST_IDLE = 5'b00001, ST_RX = 5'b00010, ST_ACK = 5'b00100,
    ST_TX = 5'b01000, ST_RACK = 5'b10000} slave_state_t;
  typedef enum logic [3:0] {PH_ADDR = 4'b0001, PH_CMD = 4'b0010, PH_COUNT = 4'b0100,
    PH_DATA = 4'b1000} byte_phase_t;
  slave_state_t state_q;
  byte_phase_t phase_q;
  logic [3:0] bit_q;
  logic [6:0] idx_q;
  logic [7:0] sh_q, tx_q, rx_byte, rd_data;
  logic read_q, block_q, sda_oe_q, byte_done, in_range, two_wire_s;
  logic [7:0] regs_q [clk_synth_pkg::NUM_REGS];
  assign two_wire_s = pin_s2[4];
  assign rx_byte = {sh_q[6:0], sda_s[1]};
  assign byte_done = (state_q == ST_RX) && scl_rise &&
    (bit_q == 4'(clk_synth_pkg::BYTE_LAST_BIT));
  assign in_range = idx_q < 7'(clk_synth_pkg::NUM_REGS);
  // indices past the bank read as zero and swallow writes
  assign rd_data = in_range ? regs_q[idx_q[1:0]] : 8'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      phase_q <= PH_ADDR;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      idx_q <= 7'h00;
      read_q <= 1'b0;
      block_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_ev) begin
      state_q <= ST_RX; // repeated start keeps command and index
      phase_q <= PH_ADDR;
      bit_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_ev) begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise) begin
            sh_q <= rx_byte;
            bit_q <= bit_q + 4'h1;
          end
          if (byte_done) begin
            state_q <= ST_ACK;
            case (phase_q)
              PH_ADDR: begin
                if (rx_byte[7:1] != clk_synth_pkg::SLAVE_ADDR) begin
                  state_q <= ST_IDLE;
                end
                read_q <= rx_byte[clk_synth_pkg::RW_BIT];
                phase_q <= PH_CMD;
              end
              PH_CMD: begin
                block_q <= ~rx_byte[clk_synth_pkg::CMD_SINGLE_BIT];
                if (rx_byte[clk_synth_pkg::CMD_SINGLE_BIT]) begin
                  idx_q <= rx_byte[6:0];
                  phase_q <= PH_DATA;
                end else begin
                  idx_q <= 7'h00;
                  phase_q <= two_wire_s ? PH_DATA : PH_COUNT;
                end
              end
              PH_COUNT: phase_q <= PH_DATA;
              default: idx_q <= idx_q + 7'h1;
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (!sda_oe_q) begin
              sda_oe_q <= 1'b1;
            end else if (read_q && phase_q == PH_CMD) begin
              // first read bit goes out on the same fall that ends the ack
              state_q <= ST_TX;
              sda_oe_q <= block_q ? ~clk_synth_pkg::BLOCK_COUNT[7] : ~rd_data[7];
              tx_q <= block_q ? {clk_synth_pkg::BLOCK_COUNT[6:0], 1'b0} : {rd_data[6:0], 1'b0};
              bit_q <= 4'h1;
              idx_q <= idx_q + 7'(!block_q);
            end else begin
              state_q <= ST_RX;
              sda_oe_q <= 1'b0;
              bit_q <= 4'h0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_q == 4'(clk_synth_pkg::ACK_BIT_IDX)) begin
              sda_oe_q <= 1'b0;
              state_q <= ST_RACK;
            end else begin
              sda_oe_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_s[1]) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_TX;
              tx_q <= rd_data;
              idx_q <= idx_q + 7'h1;
              bit_q <= 4'h0;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // ---------------------------------------------------------------------------
  // register bank
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < clk_synth_pkg::NUM_REGS; i++) begin
        regs_q[i] <= clk_synth_pkg::REG_RESET[i];
      end
    end else if (byte_done && phase_q == PH_DATA && !read_q && in_range) begin
      regs_q[idx_q[1:0]] <= rx_byte;
    end
  end
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = sda_oe_q;
  // ---------------------------------------------------------------------------
  // output fields
  // ---------------------------------------------------------------------------
  localparam int R0 = clk_synth_pkg::IDX_REF_EN, R1 = clk_synth_pkg::IDX_MISC_EN;
  localparam int R2 = clk_synth_pkg::IDX_BUS33_EN, R3 = clk_synth_pkg::IDX_LINK_DRV;
  assign diff_ref_out_en_o =
    regs_q[R0][clk_synth_pkg::REF_DIFF_HI:clk_synth_pkg::REF_DIFF_LO];
  assign shared_diff_out0_enable_o = regs_q[R0][clk_synth_pkg::REF_SHARED0];
  assign disk_video_clk_enable_o = regs_q[R1][clk_synth_pkg::MISC_DISK_VIDEO];
  assign sel_24_48_out_enable_o = regs_q[R1][clk_synth_pkg::MISC_SEL_24_48];
  assign out_48mhz_enable_o = regs_q[R1][clk_synth_pkg::MISC_48MHZ];
  assign crystal_ref_out_en_o =
    regs_q[R1][clk_synth_pkg::MISC_XREF_HI:clk_synth_pkg::MISC_XREF_LO];
  assign cpu_out_en_o = regs_q[R1][clk_synth_pkg::MISC_CPU_HI:0];
  assign bus33_out_en_o = regs_q[R2][clk_synth_pkg::BUS33_HI:0];
  assign chipset_link_out_en_o =
    regs_q[R3][clk_synth_pkg::LINK_EN_HI:clk_synth_pkg::LINK_EN_LO];
  assign bus33_drive_single_o = regs_q[R3][clk_synth_pkg::DRV_BUS33];
  assign ref_drive_single_o = regs_q[R3][clk_synth_pkg::DRV_REF];
  assign usb48_drive_single_o = regs_q[R3][clk_synth_pkg::DRV_48MHZ];
endmodule

/* rtl/clk_synth_pkg.sv */
// constants shared by the clock synthesizer serial config device and its controller
package clk_synth_pkg;
  // -------------------------------------------------------------------------
  // serial slave identity and register bank
  // -------------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h69;
  localparam int NUM_REGS = 4;
  localparam logic [6:0] IDX_REF_EN = 7'h00;
  localparam logic [6:0] IDX_MISC_EN = 7'h01;
  localparam logic [6:0] IDX_BUS33_EN = 7'h02;
  localparam logic [6:0] IDX_LINK_DRV = 7'h03;
  localparam logic [7:0] BLOCK_COUNT = 8'h04;
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {8'hf6, 8'hff, 8'hff, 8'hff};
  localparam int CMD_SINGLE_BIT = 7;
  localparam int RW_BIT = 0;
  localparam int BYTE_LAST_BIT = 7;
  localparam int ACK_BIT_IDX = 8;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int REF_DIFF_LO = 2;
  localparam int REF_DIFF_HI = 6;
  localparam int REF_SHARED0 = 0;
  localparam int MISC_DISK_VIDEO = 7;
  localparam int MISC_SEL_24_48 = 6;
  localparam int MISC_48MHZ = 5;
  localparam int MISC_XREF_HI = 4;
  localparam int MISC_XREF_LO = 2;
  localparam int MISC_CPU_HI = 1;
  localparam int BUS33_HI = 5;
  localparam int LINK_EN_HI = 7;
  localparam int LINK_EN_LO = 6;
  localparam int DRV_BUS33 = 2;
  localparam int DRV_REF = 1;
  localparam int DRV_48MHZ = 0;

  // -------------------------------------------------------------------------
  // frequency select decode
  // -------------------------------------------------------------------------
  localparam int LINK_SEL_BIT = 3;
  localparam logic [6:0] CPU_M_STD = 7'd60;
  localparam logic [6:0] CPU_M_ALT = 7'd63;
  localparam logic [8:0] CPU_N_STD = 9'd200;
  localparam logic [8:0] CPU_N_ALT = 9'd175;
  localparam logic [8:0] CPU_N_MIX = 9'd250;
  localparam logic [7:0][7:0] CPU_GEAR_TBL = {8'd60, 8'd120, 8'd30, 8'd120,
                                              8'd60, 8'd60, 8'd40, 8'd80};
  localparam logic [6:0] REF_M = 7'd60;
  localparam logic [8:0] REF_N = 9'd200;
  localparam logic [7:0] REF_GEAR = 8'd30;

  // -------------------------------------------------------------------------
  // controller timing and register map
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYCLES = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] WB_CMD = 8'h00;
  localparam logic [7:0] WB_TXDATA = 8'h04;
  localparam logic [7:0] WB_RXDATA = 8'h08;
  localparam logic [7:0] WB_STATUS = 8'h0c;
  localparam logic [2:0] OP_START = 3'h1;
  localparam logic [2:0] OP_STOP = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam int CMD_NACK_BIT = 3;
endpackage

/* rtl/serial_cfg_if.sv */
// two-wire serial link between the synthesizer and its controller
`timescale 1ns/10ps
interface serial_cfg_if;
  logic scl;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_ctrl_o;
  logic sda_ctrl_oe;
  logic sda;
  // open-drain wire with pull-up: any enabled low driver wins
  assign sda = (sda_dev_oe ? sda_dev_o : 1'b1) & (sda_ctrl_oe ? sda_ctrl_o : 1'b1);
  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport ctrl (output scl, input sda, output sda_ctrl_o, output sda_ctrl_oe);
endinterface

/* rtl/synth_cfg_ctrl.sv */
// wishbone-driven byte-level bus controller for the synthesizer serial link
`timescale 1ns/10ps
module synth_cfg_ctrl #(
  parameter int QUARTER_CYCLES = clk_synth_pkg::QUARTER_CYCLES
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial link
  serial_cfg_if.ctrl link
);
  // ---------------------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_START = 4'b0010,
    C_STOP = 4'b0100,
    C_BIT = 4'b1000
  } ctrl_state_t;
  ctrl_state_t state_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic nack_q;
  logic rd_op_q;
  logic nack_send_q;
  logic busy;
  logic req;
  logic wr;
  logic go;
  assign busy = state_q != C_IDLE;
  assign req = wb_cyc_i & wb_stb_i;
  // write lands on the edge where the master sees ack
  assign wr = req & wb_we_i & ack_q & wb_sel_i[0];
  assign go = wr && wb_adr_i == clk_synth_pkg::WB_CMD && !busy;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      case (wb_adr_i)
        clk_synth_pkg::WB_TXDATA: dat_q <= {24'h0, tx_q};
        clk_synth_pkg::WB_RXDATA: dat_q <= {24'h0, rx_q};
        clk_synth_pkg::WB_STATUS: dat_q <= {30'h0, nack_q, busy};
        default: dat_q <= 32'h0;
      endcase
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_q <= 8'h00;
    end else if (wr && wb_adr_i == clk_synth_pkg::WB_TXDATA && !busy) begin
      tx_q <= wb_dat_i[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // quarter-bit divider and bit engine
  // ---------------------------------------------------------------------------
  localparam int DIV_W = $clog2(QUARTER_CYCLES + 1);
  logic [DIV_W-1:0] div_q;
  logic tick;
  logic [1:0] qtr_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic scl_q;
  logic sda_oe_q;
  logic [1:0] sda_s;
  assign tick = busy && div_q == DIV_W'(QUARTER_CYCLES - 1);
  always_ff @(posedge clk_i) begin
    sda_s <= {sda_s[0], link.sda};
    if (rst_i || !busy || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= C_IDLE;
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      nack_q <= 1'b0;
      rd_op_q <= 1'b0;
      nack_send_q <= 1'b0;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
    end else if (go) begin
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= tx_q;
      rd_op_q <= wb_dat_i[2:0] == clk_synth_pkg::OP_READ;
      nack_send_q <= wb_dat_i[clk_synth_pkg::CMD_NACK_BIT];
      case (wb_dat_i[2:0])
        clk_synth_pkg::OP_START: state_q <= C_START;
        clk_synth_pkg::OP_STOP: state_q <= C_STOP;
        clk_synth_pkg::OP_WRITE, clk_synth_pkg::OP_READ: state_q <= C_BIT;
        default: state_q <= C_IDLE;
      endcase
    end else if (tick) begin
      qtr_q <= qtr_q + 2'h1;
      case (state_q)
        C_START: begin
          case (qtr_q)
            2'h0: sda_oe_q <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_oe_q <= 1'b1;
            default: begin
              scl_q <= 1'b0;
              state_q <= C_IDLE;
            end
          endcase
        end
        C_STOP: begin
          case (qtr_q)
            2'h0: sda_oe_q <= 1'b1;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_oe_q <= 1'b0;
            default: state_q <= C_IDLE;
          endcase
        end
        C_BIT: begin
          case (qtr_q)
            2'h0: begin
              if (bit_q == 4'(clk_synth_pkg::ACK_BIT_IDX)) begin
                sda_oe_q <= rd_op_q & ~nack_send_q;
              end else begin
                sda_oe_q <= ~rd_op_q & ~sh_q[7];
              end
            end
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              if (bit_q == 4'(clk_synth_pkg::ACK_BIT_IDX)) begin
                if (!rd_op_q) begin
                  nack_q <= sda_s[1];
                end
              end else begin
                sh_q <= {sh_q[6:0], sda_s[1]};
              end
            end
            default: begin
              scl_q <= 1'b0;
              if (bit_q == 4'(clk_synth_pkg::ACK_BIT_IDX)) begin
                rx_q <= sh_q;
                state_q <= C_IDLE;
              end else begin
                bit_q <= bit_q + 4'h1;
              end
            end
          endcase
        end
        default: state_q <= C_IDLE;
      endcase
    end
  end
  assign link.scl = scl_q;
  assign link.sda_ctrl_o = 1'b0;
  assign link.sda_ctrl_oe = sda_oe_q;
endmodule

/* sim/cfg_link_checker.sv */
// wire-level checks on the serial link between controller and device
`timescale 1ns/10ps
module cfg_link_checker (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda_ctrl_o,
  input wire logic sda_ctrl_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_dev_pulls_low: assert property (sda_dev_oe |-> !sda_dev_o && !sda)
    else $error("device drives sda other than low");
  a_ctrl_pulls_low: assert property (sda_ctrl_oe |-> !sda_ctrl_o && !sda)
    else $error("controller drives sda other than low");
  a_wire_released: assert property (!sda_dev_oe && !sda_ctrl_oe |-> sda)
    else $error("released sda not high");
  a_scl_high_len: assert property ($rose(scl) |-> scl[*8])
    else $error("scl high phase too short");
  a_scl_low_len: assert property ($fell(scl) |-> !scl[*8])
    else $error("scl low phase too short");
  a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device changed sda while scl high");
  a_dev_ack_hold: assert property ($rose(sda_dev_oe) |-> sda_dev_oe[*8])
    else $error("device low bit too short");
  a_dev_release_low: assert property ($fell(sda_dev_oe) |-> !scl)
    else $error("device released sda while scl high");
endmodule

/* sim/tb.sv */
// self-checking bench: controller and device joined over the serial link
`timescale 1ns/10ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00, rx, st;
  logic [31:0] wdat = 32'h0, rdat, wdo;
  logic [3:0] strap = 4'h0, code;
  logic pg_n = 1'b1, tmode = 1'b0, twm = 1'b0;
  logic sh0, dvid, s2448, o48, d33, dr1, d48, lfast;
  logic [4:0] dref;
  logic [2:0] xref;
  logic [1:0] cpu_en, lnk;
  logic [5:0] b33;
  logic [6:0] cm, rm;
  logic [8:0] cn, rn;
  logic [7:0] cg, rg;
  int failures = 0;
  int n_compared = 0;
  serial_cfg_if link ();
  always #5 clk_i = ~clk_i;
  synth_cfg_ctrl #(.QUARTER_CYCLES(8)) synth_cfg_ctrl_inst (.clk_i, .rst_i, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(wdo), .wb_ack_o(ack), .link(link));
  synth_cfg_device synth_cfg_device_inst (.clk_i, .rst_i, .link(link),
    .strap_freq_bit3_i(strap[3]), .strap_freq_bit2_i(strap[2]), .strap_freq_bit1_i(strap[1]),
    .strap_freq_bit0_i(strap[0]), .power_good_strobe_n_i(pg_n), .test_mode_i(tmode),
    .two_wire_mode_i(twm), .diff_ref_out_en_o(dref), .shared_diff_out0_enable_o(sh0),
    .disk_video_clk_enable_o(dvid), .sel_24_48_out_enable_o(s2448), .out_48mhz_enable_o(o48),
    .crystal_ref_out_en_o(xref), .cpu_out_en_o(cpu_en), .bus33_out_en_o(b33),
    .chipset_link_out_en_o(lnk), .bus33_drive_single_o(d33), .ref_drive_single_o(dr1),
    .usb48_drive_single_o(d48), .freq_code_o(code), .cpu_m_o(cm), .cpu_n_o(cn),
    .cpu_gear_o(cg), .ref_m_o(rm), .ref_n_o(rn), .ref_gear_o(rg), .link_fast_o(lfast));
  cfg_link_checker cfg_link_checker_inst (.clk_i, .rst_i, .scl(link.scl), .sda(link.sda),
    .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe),
    .sda_ctrl_o(link.sda_ctrl_o), .sda_ctrl_oe(link.sda_ctrl_oe));
  // ---------------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------------
  task automatic report_and_stop();
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 50 && ack !== 1'b1; i++) @(posedge clk_i);
    if (ack !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    rdat = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic op(input logic [2:0] c, input logic [7:0] tx, input logic nk = 1'b0);
    int i;
    if (c == clk_synth_pkg::OP_WRITE) wb(1'b1, clk_synth_pkg::WB_TXDATA, {24'h0, tx});
    wb(1'b1, clk_synth_pkg::WB_CMD, {28'h0, nk, c});
    for (i = 0; i < 500; i++) begin
      wb(1'b0, clk_synth_pkg::WB_STATUS, 32'h0);
      if (rdat[0] === 1'b0) break;
    end
    if (rdat[0] !== 1'b0) begin
      failures++;
      report_and_stop();
    end
    st = rdat[7:0];
    wb(1'b0, clk_synth_pkg::WB_RXDATA, 32'h0);
    rx = rdat[7:0];
  endtask
  task automatic put(input logic [7:0] b, input logic nk_exp = 1'b0);
    op(clk_synth_pkg::OP_WRITE, b);
    check("ack", st[1], nk_exp);
  endtask
  task automatic start_bus(input logic [7:0] a = 8'hd2);
    op(clk_synth_pkg::OP_START, 8'h00);
    put(a);
  endtask
  task automatic stop_bus();
    op(clk_synth_pkg::OP_STOP, 8'h00);
  endtask
  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset();
    check("enables", {dref, sh0, dvid, s2448, o48, xref, cpu_en, b33, lnk, d33, dr1, d48},
      {5'h1f, 4'hf, 3'h7, 2'h3, 6'h3f, 2'h3, 3'h6});
    check("cpu pll", {cm, cn, cg}, {7'd60, 9'd200, 8'd80});
    check("ref pll", {rm, rn, rg, lfast}, {7'd60, 9'd200, 8'd30, 1'b0});
  endtask
  task automatic t_byte();
    start_bus();
    put(8'h83);
    put(8'h3a);
    stop_bus();
    check("reg3", {lnk, d33, dr1, d48}, 5'b00010);
    start_bus();
    put(8'h82);
    put(8'hea);
    stop_bus();
    check("reg2", b33, 6'h2a);
    start_bus();
    put(8'h83);
    start_bus(8'hd3);
    op(clk_synth_pkg::OP_READ, 8'h00, 1'b1);
    stop_bus();
    check("reg3 read", rx, 8'h3a);
    op(clk_synth_pkg::OP_START, 8'h00);
    put(8'ha4, 1'b1);
    put(8'h82, 1'b1);
    put(8'h00, 1'b1);
    stop_bus();
    check("foreign", {b33, lnk}, {6'h2a, 2'b00});
  endtask
  task automatic t_block();
    logic [7:0] want [4] = '{8'h04, 8'h81, 8'h5a, 8'hea};
    start_bus();
    put(8'h00);
    put(8'h02);
    put(8'h81);
    put(8'h5a);
    stop_bus();
    check("block wr", {dref, sh0, dvid, s2448, o48, xref, cpu_en}, {6'h01, 8'h5a});
    start_bus();
    put(8'h00);
    start_bus(8'hd3);
    for (int i = 0; i < 4; i++) begin
      op(clk_synth_pkg::OP_READ, 8'h00, i == 3);
      check("block rd", rx, want[i]);
    end
    stop_bus();
    twm <= 1'b1;
    start_bus();
    put(8'h00);
    put(8'h7e);
    stop_bus();
    twm <= 1'b0;
    check("two wire", {dref, sh0}, 6'h3e);
  endtask
  task automatic t_freq();
    logic [2:0] l;
    logic [7:0] gear [8] = '{8'd80, 8'd40, 8'd60, 8'd60, 8'd120, 8'd30, 8'd120, 8'd60};
    strap <= 4'h7;
    repeat (2) @(posedge clk_i);
    pg_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    pg_n <= 1'b1;
    strap <= 4'h3;
    repeat (4) @(posedge clk_i);
    pg_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    check("one shot", {code, cn}, {4'h7, 9'd250});
    tmode <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      l = k[2:0];
      strap <= k[3:0];
      repeat (8) @(posedge clk_i);
      check("cpu", {code, cm, cn}, {k[3:0], (l == 3 || l == 4) ? 7'd63 : 7'd60,
        l == 7 ? 9'd250 : (l == 3 || l == 4) ? 9'd175 : 9'd200});
      check("ref", {rm, rn, rg, lfast}, {7'd60, 9'd200, 8'd30, k[3]});
      check("gear", cg, gear[l]);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_byte();
    t_block();
    t_freq();
    report_and_stop();
  end
endmodule
